// File: rtl/jbdsc_map.vh
`ifndef JBDSC_MAP_VH
`define JBDSC_MAP_VH
// ==========================================
// Buffer geometry
`define JBD_AW          11
`define JBD_FW          6
`define JBD_SW          5
`define JBD_SLOTS       5'h1C
`define JBD_LAST_SLOT   5'h1B
`define JBD_CENTRE      6'h20
`define JBD_MARGIN      7'sh04
// ==========================================
// Divisor values for the playback clock
`define JBD_DIV_STD     10'h24C
`define JBD_DIV_UP      10'h24D
`define JBD_DIV_DOWN    10'h24B
// ==========================================
// Muting and schedule timing
`define JBD_MUTE_FRAMES 8'h80
`define JBD_CLK_NS      40
`define JBD_FRAME_NS    136054
`define JBD_FRAME_CYC   12'hD49 // Frame period in clocks, 3401
// ==========================================
// Second-stage thresholds and flag choices
`define JBD_C1_SKIP     5'h07
`define JBD_C1_ONE_MAX  5'h05
`define JBD_C1_NONE_MAX 5'h02
`define JBD_SEL_CLEAR   2'h0
`define JBD_SEL_COPY    2'h1
`define JBD_SEL_ALL     2'h2
`endif

// File: rtl/jbdsc_c2_decide.v
`default_nettype none
`include "jbdsc_map.vh"
module jbdsc_c2_decide (
    input  wire [1:0] i_nerr,
    input  wire       i_match0,
    input  wire       i_match1,
    input  wire [4:0] i_c1_count,
    output reg        o_fix,
    output reg  [1:0] o_flag_sel
);
    // ==========================================
    // Second-stage correction and flag policy
    always @* begin
        o_fix      = 1'b0;
        o_flag_sel = `JBD_SEL_CLEAR;
        case (i_nerr)
            // RULE8: none or one error
            2'h0: o_flag_sel = `JBD_SEL_CLEAR;
            2'h1: o_fix = 1'b1;
            2'h2: begin
                if (i_c1_count >= `JBD_C1_SKIP) begin
                    // RULE10: too many first-stage flags
                    o_flag_sel = `JBD_SEL_COPY;
                end else if (i_match0 && i_match1) begin
                    // RULE9: both positions flagged
                    o_fix = 1'b1;
                end else if (i_match0 || i_match1) begin
                    // RULE11: one match only
                    o_flag_sel = (i_c1_count <= `JBD_C1_ONE_MAX) ? `JBD_SEL_ALL : `JBD_SEL_COPY;
                end else begin
                    // RULE12: no match at all
                    o_flag_sel = (i_c1_count <= `JBD_C1_NONE_MAX) ? `JBD_SEL_ALL : `JBD_SEL_COPY;
                end
            end
            default: begin
                // RULE13: three or more errors
                o_flag_sel = (i_c1_count <= `JBD_C1_NONE_MAX) ? `JBD_SEL_ALL : `JBD_SEL_COPY;
            end
        endcase
    end
endmodule
`default_nettype wire

// File: rtl/jbdsc_top.v
// Functional notes
// RULE1: 2048x8 buffer absorbs four frames jitter
// RULE2: monitor margin, steer write toward centre
// RULE3: divisor 588, 589 lagging, 587 leading
// RULE4: beyond four frames, force zero offset
// RULE5: mute output 128 frames after forcing
// RULE6: timed first stage, then second stage
// RULE7: first stage corrects two, flags two+
// RULE8: second stage none/one error clears flags
// RULE9: two errors on flagged positions corrected
// RULE10: seven+ flags: copy first-stage flags
// RULE11: one match: all if <=5, else copy
// RULE12: no match: all if <=2, else copy
// RULE13: three+ errors: all if <=2, else copy
// RULE14: output corrected symbols with flags in order
// RULE15: reset centres pointers, standard divisor, flags clear
`default_nettype none
`include "jbdsc_map.vh"
module jbdsc_top (
    input  wire        i_clk_sys,
    input  wire        i_reset_n,
    input  wire        i_sym_valid,
    input  wire        i_frame_start,
    input  wire [7:0]  i_sym_data,
    input  wire        i_chk_ack,
    input  wire [1:0]  i_chk_nerr,
    input  wire [4:0]  i_chk_pos0,
    input  wire [4:0]  i_chk_pos1,
    input  wire [7:0]  i_chk_val0,
    input  wire [7:0]  i_chk_val1,
    output reg         o_chk_req,
    output reg         o_chk_stage,
    output reg  [5:0]  o_chk_frame,
    output reg  [9:0]  o_pck_divisor,
    output reg         o_out_valid,
    output reg  [7:0]  o_out_data,
    output reg         o_out_flag,
    output reg         o_mute
);
    // ==========================================
    // States
    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_REQ   = 3'h1;
    localparam [2:0] S_FXR   = 3'h2;
    localparam [2:0] S_FXW   = 3'h3;
    localparam [2:0] S_OUT   = 3'h4;
    localparam [11:0] FRAME_CYC = `JBD_FRAME_CYC;

    // ==========================================
    // Storage and state registers
    reg [7:0]          mem [0:2047];
    reg [7:0]          ram_rd_q;
    reg [5:0]          wr_frame_q;
    reg [4:0]          wr_sym_q;
    reg [5:0]          rd_frame_q;
    reg [11:0]         tick_cnt_q;
    reg                tick_q;
    reg [7:0]          mute_cnt_q;
    reg [2:0]          state_q;
    reg                fix_idx_q;
    reg [1:0]          nfix_q;
    reg [1:0]          nerr_q;
    reg [4:0]          pos0_q;
    reg [4:0]          pos1_q;
    reg [7:0]          val0_q;
    reg [7:0]          val1_q;
    reg [27:0]         c1_hist_q;
    reg [27:0]         c2_flags_q;
    reg [4:0]          out_idx_q;
    reg                out_pend_q;
    reg [4:0]          out_slot_q;

    wire [4:0]         fix_pos = fix_idx_q ? pos1_q : pos0_q;
    wire [7:0]         fix_val = fix_idx_q ? val1_q : val0_q;
    wire [6:0]         offset  = {1'b0, wr_frame_q - rd_frame_q} - {1'b0, `JBD_CENTRE};
    wire signed [6:0]  offs_s  = offset;
    wire               demod_we = i_sym_valid;
    wire               fix_we   = (state_q == S_FXW) && !i_sym_valid;
    // Frame start symbol opens slot 0 of the next frame
    wire [10:0]        wr_addr  = !demod_we     ? {o_chk_frame, fix_pos} :
                                  i_frame_start ? {wr_frame_q + 6'h01, 5'h00}
                                                : {wr_frame_q, wr_sym_q};
    wire [10:0]        rd_addr  = (state_q == S_OUT) ? {rd_frame_q, out_idx_q}
                                                      : {o_chk_frame, fix_pos};
    wire               match0   = (i_chk_pos0 < `JBD_SLOTS) && c1_hist_q[i_chk_pos0];
    wire               match1   = (i_chk_pos1 < `JBD_SLOTS) && c1_hist_q[i_chk_pos1];
    wire               c2_fix;
    wire [1:0]         c2_sel;
    reg  [4:0]         c1_count;
    integer            k;

    // ==========================================
    // Count of first-stage flags in the second-stage word
    always @* begin
        c1_count = 5'h00;
        for (k = 0; k < 28; k = k + 1) begin
            c1_count = c1_count + {4'h0, c1_hist_q[k]};
        end
    end

    // Second-stage decision table
    jbdsc_c2_decide jbdsc_c2_decide_inst (
        .i_nerr     (i_chk_nerr),
        .i_match0   (match0),
        .i_match1   (match1),
        .i_c1_count (c1_count),
        .o_fix      (c2_fix),
        .o_flag_sel (c2_sel)
    );

    // ==========================================
    // RULE1: buffer memory, demod writes win
    always @(posedge i_clk_sys) begin
        if (demod_we || fix_we) begin
            mem[wr_addr] <= demod_we ? i_sym_data : (ram_rd_q ^ fix_val);
        end
        ram_rd_q <= mem[rd_addr];
    end

    // ==========================================
    // Reference frame schedule from the system clock
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tick_cnt_q <= 12'h000;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == FRAME_CYC - 12'h001) begin
            tick_cnt_q <= 12'h000;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 12'h001;
            tick_q     <= 1'b0;
        end
    end

    // ==========================================
    // Write pointer, centring and forced recentre
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            // RULE15: start at zero offset
            wr_frame_q    <= `JBD_CENTRE;
            wr_sym_q      <= 5'h00;
            o_pck_divisor <= `JBD_DIV_STD;
            mute_cnt_q    <= 8'h00;
            o_mute        <= 1'b0;
        end else begin
            if (tick_q && (offs_s > `JBD_MARGIN || offs_s < -`JBD_MARGIN)) begin
                // RULE4: force back to zero offset
                wr_frame_q <= rd_frame_q + `JBD_CENTRE;
                wr_sym_q   <= 5'h00;
                // RULE5: mute for 128 frames
                mute_cnt_q <= `JBD_MUTE_FRAMES;
            end else begin
                if (i_sym_valid && i_frame_start) begin
                    wr_frame_q <= wr_frame_q + 6'h01;
                    wr_sym_q   <= 5'h01;
                end else if (i_sym_valid) begin
                    wr_sym_q <= wr_sym_q + 5'h01;
                end
                if (tick_q && mute_cnt_q != 8'h00) begin
                    mute_cnt_q <= mute_cnt_q - 8'h01;
                end
            end
            o_mute <= (mute_cnt_q != 8'h00);
            // RULE2: steer write toward centre
            // RULE3: trim playback clock divisor
            if (offs_s < 7'sh00) begin
                o_pck_divisor <= `JBD_DIV_UP;
            end else if (offs_s > 7'sh00) begin
                o_pck_divisor <= `JBD_DIV_DOWN;
            end else begin
                o_pck_divisor <= `JBD_DIV_STD;
            end
        end
    end

    // ==========================================
    // Correction sequencer and output stream
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q     <= S_IDLE;
            o_chk_req   <= 1'b0;
            o_chk_stage <= 1'b0;
            o_chk_frame <= 6'h00;
            rd_frame_q  <= 6'h00;
            fix_idx_q   <= 1'b0;
            nfix_q      <= 2'h0;
            nerr_q      <= 2'h0;
            pos0_q      <= 5'h00;
            pos1_q      <= 5'h00;
            val0_q      <= 8'h00;
            val1_q      <= 8'h00;
            c1_hist_q   <= 28'h0000000;
            c2_flags_q  <= 28'h0000000;
            out_idx_q   <= 5'h00;
            out_pend_q  <= 1'b0;
            out_slot_q  <= 5'h00;
            o_out_valid <= 1'b0;
            o_out_data  <= 8'h00;
            o_out_flag  <= 1'b0;
        end else begin
            // RULE14: registered symbol with its flag
            o_out_valid <= out_pend_q;
            out_pend_q  <= 1'b0;
            if (out_pend_q) begin
                o_out_data <= ram_rd_q;
                o_out_flag <= c2_flags_q[out_slot_q];
            end
            case (state_q)
                S_IDLE: begin
                    // RULE6: first stage on each frame tick
                    if (tick_q) begin
                        o_chk_req   <= 1'b1;
                        o_chk_stage <= 1'b0;
                        o_chk_frame <= rd_frame_q;
                        state_q     <= S_REQ;
                    end
                end
                S_REQ: begin
                    if (i_chk_ack) begin
                        o_chk_req <= 1'b0;
                        nerr_q    <= i_chk_nerr;
                        pos0_q    <= i_chk_pos0;
                        pos1_q    <= i_chk_pos1;
                        val0_q    <= i_chk_val0;
                        val1_q    <= i_chk_val1;
                        fix_idx_q <= 1'b0;
                        if (!o_chk_stage) begin
                            // RULE7: fix up to two, flag two+
                            c1_hist_q <= {c1_hist_q[26:0], i_chk_nerr[1]};
                            nfix_q    <= (i_chk_nerr == 2'h3) ? 2'h0 : i_chk_nerr;
                        end else begin
                            nfix_q <= c2_fix ? i_chk_nerr : 2'h0;
                            case (c2_sel)
                                `JBD_SEL_COPY: c2_flags_q <= c1_hist_q;
                                `JBD_SEL_ALL:  c2_flags_q <= 28'hFFFFFFF;
                                default:       c2_flags_q <= 28'h0000000;
                            endcase
                        end
                        if ((!o_chk_stage && i_chk_nerr != 2'h0 && i_chk_nerr != 2'h3)
                            || (o_chk_stage && c2_fix)) begin
                            state_q <= S_FXR;
                        end else if (!o_chk_stage) begin
                            // RULE6: then second stage
                            o_chk_req   <= 1'b1;
                            o_chk_stage <= 1'b1;
                        end else begin
                            out_idx_q <= 5'h00;
                            state_q   <= S_OUT;
                        end
                    end
                end
                S_FXR: state_q <= S_FXW;
                S_FXW: begin
                    if (!i_sym_valid) begin
                        if (!fix_idx_q && nfix_q == 2'h2) begin
                            fix_idx_q <= 1'b1;
                            state_q   <= S_FXR;
                        end else if (!o_chk_stage) begin
                            o_chk_req   <= 1'b1;
                            o_chk_stage <= 1'b1;
                            state_q     <= S_REQ;
                        end else begin
                            out_idx_q <= 5'h00;
                            state_q   <= S_OUT;
                        end
                    end
                end
                S_OUT: begin
                    out_pend_q <= 1'b1;
                    out_slot_q <= out_idx_q;
                    out_idx_q  <= out_idx_q + 5'h01;
                    if (out_idx_q == `JBD_LAST_SLOT) begin
                        rd_frame_q <= rd_frame_q + 6'h01;
                        state_q    <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: verif/jbdsc_top_props.sv
`default_nettype none
// ==========================================
// Port checks on the buffer and correction
module jbdsc_props (
    input wire logic       i_clk_sys,
    input wire logic       i_reset_n,
    input wire logic       i_chk_ack,
    input wire logic       o_chk_req,
    input wire logic       o_chk_stage,
    input wire logic [5:0] o_chk_frame,
    input wire logic [9:0] o_pck_divisor,
    input wire logic       o_out_valid,
    input wire logic       o_mute
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] run_q;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    // Length of the current output burst
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            run_q <= 6'h00;
        end else begin
            run_q <= o_out_valid ? run_q + 6'h01 : 6'h00;
        end
    end
    // ==========================================
    // Divisor, forcing and muting
    div_legal_a: assert property (o_pck_divisor inside {10'h24B, 10'h24C, 10'h24D})
        else $error("divisor off its values");
    reset_state_a: assert property ($rose(i_reset_n) |->
        o_pck_divisor == 10'h24C && !o_mute) else $error("bad state after reset");
    force_lead_a: assert property ($rose(o_mute) |-> $past(o_pck_divisor, 3) != 10'h24C)
        else $error("forced while centred");
    force_centre_a: assert property ($rose(o_mute) |-> ##[0:3] o_pck_divisor == 10'h24C)
        else $error("not centred after force");
    mute_hold_a: assert property ($rose(o_mute) |-> o_mute[*8])
        else $error("mute too short");
    // ==========================================
    // Check schedule and output burst
    req_hold_a: assert property (o_chk_req && !i_chk_ack |=>
        o_chk_req && $stable(o_chk_frame)) else $error("request dropped early");
    stage_order_a: assert property (o_chk_req && i_chk_ack && !o_chk_stage |->
        ##[1:12] (o_chk_req && o_chk_stage)) else $error("no second stage");
    out_follow_a: assert property (o_chk_req && i_chk_ack && o_chk_stage |=>
        !o_chk_req ##[1:12] o_out_valid) else $error("no output burst");
    burst_len_a: assert property ($fell(o_out_valid) |-> run_q == 6'h1C)
        else $error("burst length wrong");
endmodule
bind jbdsc_top jbdsc_props jbdsc_props_inst (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_chk_ack(i_chk_ack),
    .o_chk_req(o_chk_req), .o_chk_stage(o_chk_stage), .o_chk_frame(o_chk_frame),
    .o_pck_divisor(o_pck_divisor), .o_out_valid(o_out_valid), .o_mute(o_mute));
`default_nettype wire

// File: verif/jbdsc_chk_model.sv
`default_nettype none
// ==========================================
// Error checker stand-in answering requests
module jbdsc_chk_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_chk_req,
    input  wire logic        i_chk_stage,
    input  wire logic [14:0] i_cfg,
    output var  logic        o_chk_ack,
    output wire logic [1:0]  o_chk_nerr,
    output wire logic [4:0]  o_chk_pos0,
    output wire logic [4:0]  o_chk_pos1,
    output wire logic [7:0]  o_chk_val
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_q = 4'h0;
    // One-cycle ack, at once or after a stall
    always @(posedge i_clk_sys) begin
        o_chk_ack <= 1'b0;
        wait_q <= 4'h0;
        if (i_chk_req && !o_chk_ack) begin
            wait_q <= wait_q + 4'h1;
            o_chk_ack <= (wait_q >= (i_cfg[14] ? 4'h6 : 4'h0));
        end
    end
    // Results only with ack, scrambled otherwise
    assign o_chk_nerr = !o_chk_ack ? ~i_cfg[11:10] : i_chk_stage ? i_cfg[11:10] : i_cfg[13:12];
    assign o_chk_pos0 = o_chk_ack ? i_cfg[9:5] : ~i_cfg[9:5];
    assign o_chk_pos1 = o_chk_ack ? i_cfg[4:0] : ~i_cfg[4:0];
    assign o_chk_val = o_chk_ack ? 8'h5A : 8'hA5;
endmodule
`default_nettype wire

// File: verif/test_jitter_buffer_dual_stage_correction.sv
`default_nettype none
module test_jitter_buffer_dual_stage_correction;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        sym_v = 1'b0;
    logic        fs = 1'b0;
    logic [7:0]  sym = 8'h00;
    logic [14:0] cfg = 15'h0000;
    logic [27:0] hist = 28'h0000000;
    logic [27:0] got;
    logic        ack, req, stg, ov, oflag, mute;
    logic [1:0]  nerr;
    logic [4:0]  p0, p1;
    logic [5:0]  frm;
    logic [7:0]  val, odat, d0;
    logic [9:0]  div;
    int          num_errors = 0;
    int          checks_done = 0;
    int          off = 0;
    jbdsc_top jbdsc_top_inst (.i_clk_sys(clk), .i_reset_n(rst_n), .i_sym_valid(sym_v),
        .i_frame_start(fs), .i_sym_data(sym), .i_chk_ack(ack), .i_chk_nerr(nerr),
        .i_chk_pos0(p0), .i_chk_pos1(p1), .i_chk_val0(val), .i_chk_val1(val),
        .o_chk_req(req), .o_chk_stage(stg), .o_chk_frame(frm), .o_pck_divisor(div),
        .o_out_valid(ov), .o_out_data(odat), .o_out_flag(oflag), .o_mute(mute));
    jbdsc_chk_model jbdsc_chk_model_inst (.i_clk_sys(clk), .i_chk_req(req),
        .i_chk_stage(stg), .i_cfg(cfg), .o_chk_ack(ack), .o_chk_nerr(nerr),
        .o_chk_pos0(p0), .o_chk_pos1(p1), .o_chk_val(val));
    // 25 MHz clock
    always #20 clk = ~clk;
    task automatic check(input logic [27:0] seen, input logic [27:0] want);
        checks_done++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected at %0t: seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic results();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // One tick: collect the flag burst, then write k frame starts
    task automatic run_tick(input logic [1:0] n0, n1, input logic [4:0] a, b, input int k);
        int i;
        cfg = {~cfg[14], n0, n1, a, b};
        got = 28'h0000000;
        for (i = 0; i < 5000 && ov !== 1'b1; i++) @(posedge clk) #1;
        check(ov, 1'b1);
        d0 = odat;
        for (i = 0; i < 28 && ov === 1'b1; i++) begin
            got[i] = oflag;
            @(posedge clk) #1;
        end
        hist = {hist[26:0], n0 >= 2'h2};
        off = off + k - 1;
        repeat (k) begin
            sym_v = 1'b1;
            fs = 1'b1;
            sym = sym + 8'h3B;
            @(posedge clk) #1;
        end
        sym_v = 1'b0;
        fs = 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // Expected second-stage flags
    function automatic logic [27:0] exp_flags(input logic [1:0] n, input logic [4:0] a, b);
        int c;
        int lim;
        c = $countones(hist);
        if (n < 2'h2) return 28'h0000000;
        if (n == 2'h2 && c < 7 && hist[a] && hist[b]) return 28'h0000000;
        lim = (n == 2'h2 && c < 7 && (hist[a] || hist[b])) ? 5 : 2;
        return (c <= lim) ? 28'hFFFFFFF : hist;
    endfunction
    task automatic check_div();
        check(div, off < 0 ? 10'h24D : off > 0 ? 10'h24B : 10'h24C);
    endtask
    task automatic test_reset_state();
        check({div, req, ov, mute}, {10'h24C, 3'h0});
    endtask
    task automatic test_flag_table();
        byte n0[14] = '{0, 0, 0, 0, 2, 2, 2, 2, 2, 2, 2, 2, 3, 1};
        byte n1[14] = '{0, 1, 2, 3, 2, 2, 3, 2, 2, 2, 2, 2, 1, 3};
        byte a[14] = '{0, 0, 3, 0, 0, 0, 0, 20, 0, 0, 0, 0, 0, 0};
        byte b[14] = '{0, 0, 4, 0, 5, 1, 0, 21, 20, 1, 1, 20, 0, 0};
        for (int t = 0; t < 14; t++) begin
            run_tick(n0[t][1:0], n1[t][1:0], a[t][4:0], b[t][4:0], 1);
            check(got, exp_flags(n1[t][1:0], a[t][4:0], b[t][4:0]));
            check_div();
        end
    endtask
    // Writer runs ahead, then starves
    task automatic test_drift();
        run_tick(2'h0, 2'h0, 5'h00, 5'h00, 3);
        check_div();
        repeat (7) begin
            run_tick(2'h0, 2'h0, 5'h00, 5'h00, 0);
            check_div();
        end
    endtask
    // Offset past the margin forces and mutes
    task automatic test_force();
        check(mute, 1'b0);
        run_tick(2'h0, 2'h0, 5'h00, 5'h00, 1);
        check(mute, 1'b1);
        off = 0;
        check_div();
    endtask
    // Writer wraps onto the next read frame, is forced, slot 0 corrected
    task automatic test_data();
        logic [7:0] want_d;
        run_tick(2'h0, 2'h0, 5'h00, 5'h00, 33);
        off = off - 64;
        check_div();
        want_d = sym ^ 8'h5A;
        run_tick(2'h1, 2'h0, 5'h00, 5'h00, 1);
        off = 0;
        check_div();
        check(d0, want_d);
        check(got, exp_flags(2'h0, 5'h00, 5'h00));
    endtask
    // Watchdog
    initial begin
        repeat (90000) @(posedge clk);
        num_errors++;
        results();
    end
    initial begin
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        @(posedge clk) #1;
        test_reset_state();
        test_flag_table();
        test_drift();
        test_force();
        test_data();
        results();
    end
endmodule
`default_nettype wire
